// ---- verilog/timer_ctrl_pkg.sv ----
/*
 * Constants for the gated, prescaled timer control block: register map,
 * control field positions, reset values and prescaler terminal counts.
 * Assumes a 32-bit classic Wishbone master and a single 25 MHz clock.
 */
package timer_ctrl_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          ADR_W        = 4;
	localparam logic [1:0]  WORD_CTRL    = 2'h0;
	localparam logic [1:0]  WORD_STATUS  = 2'h1;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int          RUN_BIT      = 15;
	localparam int          IDLE_BIT     = 13;
	localparam int          GATE_BIT     = 6;
	localparam int          PRE_HI       = 5;
	localparam int          PRE_LO       = 4;
	localparam int          PAIR_BIT     = 3;
	localparam int          SRC_BIT      = 1;
	localparam logic [15:0] CTRL_MASK    = 16'hA07A;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;

	// ****************************************************************
	// Status register fields
	// ****************************************************************
	localparam int          ST_ACTIVE    = 0;
	localparam int          ST_GATE      = 1;
	localparam int          ST_WIDE      = 2;
	localparam int          ST_PRE_LO    = 8;
	localparam int          ST_PRE_HI    = 15;

	// ****************************************************************
	// Prescaler terminal counts
	// ****************************************************************
	localparam logic [1:0]  PRE_DIV1     = 2'h0;
	localparam logic [1:0]  PRE_DIV8     = 2'h1;
	localparam logic [1:0]  PRE_DIV64    = 2'h2;
	localparam logic [1:0]  PRE_DIV256   = 2'h3;
	localparam logic [7:0]  TERM_DIV1    = 8'h00;
	localparam logic [7:0]  TERM_DIV8    = 8'h07;
	localparam logic [7:0]  TERM_DIV64   = 8'h3F;
	localparam logic [7:0]  TERM_DIV256  = 8'hFF;

endpackage

// ---- verilog/timer_ctrl.sv ----
/*
 * Timer control: Wishbone-reached control register, clock source and gate
 * selection, input prescaler and idle handling. Emits one count pulse per
 * prescaled timer clock to the counter that sits outside this block.
 * Assumes the peripheral clock enable comes from the doze divider on i_clk,
 * idle comes from the power manager on i_clk, and the pin is asynchronous.
 */
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module timer_ctrl #(
	parameter bit                          HAS_EXT_PIN = 1'b1
) (
	input  wire logic                          i_clk,
	input  wire logic                          i_rst_b,
	input  wire logic                          i_wb_cyc,
	input  wire logic                          i_wb_stb,
	input  wire logic                          i_wb_we,
	input  wire logic [timer_ctrl_pkg::ADR_W-1:0] i_wb_adr,
	input  wire logic [3:0]                    i_wb_sel,
	input  wire logic [31:0]                   i_wb_dat,
	output      logic [31:0]                   o_wb_dat,
	output      logic                          o_wb_ack,
	input  wire logic                          i_periph_en,
	input  wire logic                          i_idle,
	input  wire logic                          i_ext_pin,
	output      logic                          o_count_tick,
	output      logic                          o_wide_mode,
	output      logic                          o_run_active
);
	import timer_ctrl_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [15:0] ctrl;
		logic [2:0]  sync;
		logic        pin_level;
		logic [7:0]  pre_cnt;
		logic        tick;
		logic        wide;
		logic        active;
		logic        ack;
		logic [31:0] rdat;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic        req;
	logic        wr_take;
	logic [1:0]  word;
	logic [15:0] wr_val;
	logic [15:0] wmask;
	logic        pin_stable;
	logic        pin_new;
	logic        ext_rise;
	logic        src_ext;
	logic        gate_on;
	logic        halted;
	logic        src_tick;
	logic [7:0]  term;
	logic [31:0] status;
	logic [31:0] rd_mux;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_nxt  = st_r;
		req     = i_wb_cyc & i_wb_stb;
		word    = i_wb_adr[ADR_W-1:2];
		wr_take = req & i_wb_we & st_r.ack;
		wmask   = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}} & CTRL_MASK;
		if (!HAS_EXT_PIN) begin
			wmask[SRC_BIT] = 1'b0;
		end
		wr_val = (st_r.ctrl & ~wmask) | (i_wb_dat[15:0] & wmask);

		// Pin: three flops, change accepted when second and third agree
		st_nxt.sync = {st_r.sync[1:0], i_ext_pin};
		pin_stable  = (st_r.sync[1] == st_r.sync[2]);
		pin_new     = pin_stable ? st_r.sync[2] : st_r.pin_level;
		st_nxt.pin_level = pin_new;
		ext_rise    = pin_new & ~st_r.pin_level;

		// Source selection and gating
		src_ext  = HAS_EXT_PIN & st_r.ctrl[SRC_BIT];
		gate_on  = st_r.ctrl[GATE_BIT] & ~src_ext;
		halted   = st_r.ctrl[IDLE_BIT] & i_idle;
		if (src_ext) begin
			src_tick = ext_rise;
		end else begin
			src_tick = i_periph_en & (~gate_on | st_r.pin_level);
		end

		unique case (st_r.ctrl[PRE_HI:PRE_LO])
			PRE_DIV1:   term = TERM_DIV1;
			PRE_DIV8:   term = TERM_DIV8;
			PRE_DIV64:  term = TERM_DIV64;
			PRE_DIV256: term = TERM_DIV256;
		endcase

		// Prescaler and count pulse
		st_nxt.tick   = 1'b0;
		st_nxt.active = st_r.ctrl[RUN_BIT] & ~halted;
		if (!st_r.ctrl[RUN_BIT]) begin
			st_nxt.pre_cnt = 8'h00;
		end else if (!halted && src_tick) begin
			if (st_r.pre_cnt >= term) begin
				st_nxt.pre_cnt = 8'h00;
				st_nxt.tick    = 1'b1;
			end else begin
				st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
			end
		end
		st_nxt.wide = st_r.ctrl[PAIR_BIT];

		// Wishbone slave
		status = 32'h0000_0000;
		status[ST_ACTIVE] = st_r.active;
		status[ST_GATE]   = st_r.pin_level;
		status[ST_WIDE]   = st_r.wide;
		status[ST_PRE_HI:ST_PRE_LO] = st_r.pre_cnt;
		unique case (word)
			WORD_CTRL:   rd_mux = {16'h0000, st_r.ctrl};
			WORD_STATUS: rd_mux = status;
			default:     rd_mux = 32'h0000_0000;
		endcase
		st_nxt.ack = req & ~st_r.ack;
		if (req && !st_r.ack) begin
			st_nxt.rdat = rd_mux;
		end
		if (wr_take && word == WORD_CTRL) begin
			st_nxt.ctrl = wr_val;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r.ctrl      <= CTRL_RESET;
			st_r.sync      <= 3'h0;
			st_r.pin_level <= 1'b0;
			st_r.pre_cnt   <= 8'h00;
			st_r.tick      <= 1'b0;
			st_r.wide      <= 1'b0;
			st_r.active    <= 1'b0;
			st_r.ack       <= 1'b0;
			st_r.rdat      <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_wb_dat     = st_r.rdat;
	assign o_wb_ack     = st_r.ack;
	assign o_count_tick = st_r.tick;
	assign o_wide_mode  = st_r.wide;
	assign o_run_active = st_r.active;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_stopped_no_tick: assert property (!st_r.ctrl[RUN_BIT] |=> !o_count_tick)
		else $error("count pulse while run bit clear");
	a_wide_starts: assert property (
		st_r.ctrl[RUN_BIT] && st_r.ctrl[PAIR_BIT] && !halted && src_tick
		&& st_r.pre_cnt >= term |=> o_count_tick && o_wide_mode)
		else $error("paired timer missed its count pulse");
	a_single_starts: assert property (
		st_r.ctrl[RUN_BIT] && !st_r.ctrl[PAIR_BIT] && !halted && src_tick
		&& st_r.pre_cnt >= term |=> o_count_tick && !o_wide_mode)
		else $error("single timer missed its count pulse");
	a_ext_ignores_gate: assert property (
		src_ext && st_r.ctrl[GATE_BIT] && st_r.ctrl[RUN_BIT] && !halted
		&& ext_rise && term == TERM_DIV1 |=> o_count_tick)
		else $error("gate bit blocked external counting");
	a_prescale_bound: assert property (
		st_r.pre_cnt > term |=> st_r.pre_cnt == $past(st_r.pre_cnt) || st_r.pre_cnt == 8'h00)
		else $error("prescaler passed its terminal count");
	a_div8_spacing: assert property (
		o_count_tick && term == TERM_DIV8 && !src_ext && !gate_on
		|-> ##1 !o_count_tick [*7])
		else $error("divide-by-8 pulses too close");
	a_wide_follows: assert property (
		wr_take && word == WORD_CTRL && i_wb_sel[0] && i_wb_dat[PAIR_BIT]
		|=> ##1 o_wide_mode)
		else $error("pairing bit did not reach wide output");
	a_ext_edge_only: assert property (src_ext && !ext_rise |=> !o_count_tick)
		else $error("external count without a pin rising edge");
	a_ctrl_readback: assert property (
		o_wb_ack && !i_wb_we && word == WORD_CTRL
		|-> o_wb_dat[31:16] == 16'h0000 && (o_wb_dat[15:0] & ~CTRL_MASK) == 16'h0000)
		else $error("reserved control bits read nonzero");
	a_pinless_source: assert property (!HAS_EXT_PIN |-> !st_r.ctrl[SRC_BIT])
		else $error("external source used without a pin");
	a_periph_only: assert property (
		!src_ext && !i_periph_en |=> !o_count_tick)
		else $error("internal count without peripheral enable");
	a_idle_halts: assert property (st_r.ctrl[IDLE_BIT] && i_idle |=> !o_count_tick)
		else $error("count pulse during idle with idle stop");
	a_idle_runs_on: assert property (
		st_r.ctrl[RUN_BIT] && !st_r.ctrl[IDLE_BIT] && i_idle |=> o_run_active)
		else $error("timer halted in idle without idle stop");
	a_gate_low_blocks: assert property (
		gate_on && !st_r.pin_level |=> !o_count_tick)
		else $error("gated count while gate low");
	a_gate_high_counts: assert property (
		gate_on && st_r.pin_level && st_r.ctrl[RUN_BIT] && !halted && i_periph_en
		&& st_r.pre_cnt >= term |=> o_count_tick)
		else $error("gated count missing while gate high");
	a_ack_answers: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");

	c_wide_tick:   cover property (o_wide_mode && o_count_tick);
	c_ext_tick:    cover property (src_ext && o_count_tick);
	c_gated_tick:  cover property (gate_on && o_count_tick);
	c_idle_halt:   cover property (st_r.ctrl[RUN_BIT] && halted ##1 !o_run_active);
	c_div256_tick: cover property (term == TERM_DIV256 && o_count_tick);

endmodule

// ---- verif/ext_pin_model.sv ----
/*
 * Far-side model of the external clock/gate pin.
 * Assumes the bench clock; mode 0 low, 1 high, 2 toggles every 4 cycles.
 */
`timescale 1ns/10ps
module ext_pin_model (
	input  wire logic       i_clk,
	input  wire logic [1:0] i_mode,
	output      logic       o_pin
);
	logic [1:0] ph_r  = 2'h0;
	logic       pin_r = 1'b0;
	assign o_pin = pin_r;
	// Rising edge once per 8 cycles in toggle mode
	always @(posedge i_clk) begin
		ph_r  <= ph_r + 2'h1;
		pin_r <= (i_mode == 2'h2) ? (pin_r ^ (ph_r == 2'h3)) : i_mode[0];
	end
endmodule

// ---- verif/tb_timer_ctrl.sv ----
/*
 * Self-checking bench for timer_ctrl: Wishbone register access and tick rates.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_timer_ctrl;
	import timer_ctrl_pkg::*;
	logic i_clk = 0, i_rst_b = 0, cyc = 0, stb = 0, we = 0, pe = 1, pe_tog = 0, idle = 0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rd, o_wb_dat, rd_np, dat_np;
	logic o_wb_ack, o_count_tick, o_wide_mode, o_run_active, pin;
	logic [1:0] pin_mode = 2'h0;
	logic [15:0] tick_cnt = 16'h0, n0;
	int err_count = 0, tests_run = 0;
	logic [15:0] divs [4] = '{16'h0200, 16'h0040, 16'h0008, 16'h0002};
	always #20 i_clk = ~i_clk;
	timer_ctrl u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack), .i_periph_en(pe), .i_idle(idle), .i_ext_pin(pin),
		.o_count_tick(o_count_tick), .o_wide_mode(o_wide_mode), .o_run_active(o_run_active));
	ext_pin_model u_pin (.i_clk(i_clk), .i_mode(pin_mode), .o_pin(pin));
	timer_ctrl #(.HAS_EXT_PIN(1'b0)) u_dut_nopin (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(dat_np), .o_wb_ack(), .i_periph_en(pe), .i_idle(idle),
		.i_ext_pin(pin), .o_count_tick(), .o_wide_mode(), .o_run_active());
	always @(posedge i_clk) begin
		if (o_count_tick === 1'b1) tick_cnt <= tick_cnt + 16'h1;
		pe <= pe_tog ? !pe : 1'b1;
	end
	// ************************************************
	// Bus and measurement tasks
	// ************************************************
	task wb(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hF; wdat <= {16'h0, d};
		do begin @(posedge i_clk); end while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		rd_np = dat_np;
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task m(input logic [15:0] c, input logic [15:0] exp);
		wb(1, 4'h0, c);
		repeat (40) @(posedge i_clk);
		n0 = tick_cnt;
		repeat (512) @(posedge i_clk);
		`CHK(tick_cnt - n0, exp)
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge i_clk);
		err_count++;
		print_verdict;
	end
	// ************************************************
	// Tests
	// ************************************************
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1;
		wb(0, 4'h0, 16'h0); `CHK(rd, 32'h0)
		wb(1, 4'h0, 16'hFFFF); wb(0, 4'h0, 16'h0); `CHK(rd, 32'h0000A07A)
		`CHK(rd_np, 32'h0000A078)
		wb(1, 4'h8, 16'h0000); `CHK(rd, 32'h0)
		wb(1, 4'h4, 16'h0000); wb(0, 4'h0, 16'h0); `CHK(rd, 32'h0000A07A)
		$display("register test done");
		m(16'h0008, 16'h0); `CHK(o_wide_mode, 1'b1)
		`CHK(o_run_active, 1'b0)
		m(16'h8008, 16'h0200); `CHK(o_run_active, 1'b1)
		wb(0, 4'h4, 16'h0); `CHK(rd, 32'h0000_0005)
		m(16'h0000, 16'h0); `CHK(o_wide_mode, 1'b0)
		m(16'h8000, 16'h0200);
		$display("run and pairing test done");
		for (int k = 0; k < 4; k++) m(16'h8000 | 16'(k << 4), divs[k]);
		pe_tog <= 1; m(16'h8000, 16'h0100); pe_tog <= 0;
		$display("prescale test done");
		idle <= 1; m(16'hA000, 16'h0); `CHK(o_run_active, 1'b0)
		m(16'h8000, 16'h0200); `CHK(o_run_active, 1'b1)
		idle <= 0;
		$display("idle test done");
		pin_mode <= 2'h2; m(16'h8002, 16'h0040);
		m(16'h8012, 16'h0008);
		m(16'h8042, 16'h0040);
		pin_mode <= 2'h0; m(16'h8040, 16'h0);
		pin_mode <= 2'h1; m(16'h8040, 16'h0200);
		m(16'h8000, 16'h0200);
		$display("source and gate test done");
		print_verdict;
	end
endmodule
